// File: hdl/ebr_block_ram.sv
`include "ebr_map.svh"
// Summary of operation
// - writes are taken through input registers on the port clock edge.
// - output register stage is optional per port; input registers always present.
// - storage holds 4608 bits, parity bits included.
// - shapes 4Kx1 up to 128x36 map address and data onto storage.
// - true dual-port mode refuses the 32 and 36 bit shapes.
// - one parity bit stored beside each byte; user logic computes it.
// - byte write masking works for every supported port width.
// - bytes with byte enable low keep their previous contents.
// - two half-size single-clock single-port memories may share the block.
// - address hold keeps the previous address in the address register.
// - contents preload from an initialisation image before any write.
// - same-port read during write returns the new data.
// - mixed-port read during write returns the old data.
// - true dual-port allows two reads, two writes, or one of each.
// - write port registers write inputs; read port registers read inputs and data.
// - one clock drives all registers, with no asynchronous clear.
module ebr_block_ram #(
    parameter logic [`EBR_BITS-1:0] INIT_IMAGE = '0
) (
    // clock and reset
    input logic clk_sys_i,
    input logic sys_rst_i,
    // configuration
    input ebr_pkg::ebr_mode_t mode_i,
    input logic packed_i,
    input ebr_pkg::ebr_shape_t a_shape_i,
    input ebr_pkg::ebr_shape_t b_shape_i,
    input logic a_outreg_i,
    input logic b_outreg_i,
    // port a
    input logic a_en_i,
    input logic a_addr_hold_i,
    input logic [`EBR_ADDR_W-1:0] a_addr_i,
    input logic [`EBR_DATA_W-1:0] a_din_i,
    input logic [`EBR_LANES-1:0] a_be_i,
    input logic a_we_i,
    input logic a_rd_i,
    output logic [`EBR_DATA_W-1:0] a_q_o,
    // port b
    input logic b_en_i,
    input logic b_addr_hold_i,
    input logic [`EBR_ADDR_W-1:0] b_addr_i,
    input logic [`EBR_DATA_W-1:0] b_din_i,
    input logic [`EBR_LANES-1:0] b_be_i,
    input logic b_we_i,
    input logic b_rd_i,
    output logic [`EBR_DATA_W-1:0] b_q_o,
    // status
    output logic cfg_err_o
);
    // memory array, loaded from the image at power-up only
    typedef logic [`EBR_BYTE_W-1:0] ebr_store_t [`EBR_BYTES];
    ebr_store_t mem = load_image();
    logic [`EBR_ADDR_W-1:0] p_addr [2];
    logic [`EBR_DATA_W-1:0] p_din [2];
    logic [`EBR_LANES-1:0] p_be [2];
    logic p_en [2];
    logic p_hold [2];
    logic p_we [2];
    logic p_rd [2];
    logic outreg [2];
    ebr_pkg::ebr_shape_t shape [2];
    logic pk;
    logic [1:0] wide;
    // input registers: no clear, zero only at power-up
    logic [`EBR_ADDR_W-1:0] in_addr [2] = '{default: '0};
    logic [`EBR_DATA_W-1:0] in_din [2] = '{default: '0};
    logic [`EBR_LANES-1:0] in_be [2] = '{default: '0};
    logic in_we [2] = '{default: 1'b0};
    logic in_rd [2] = '{default: 1'b0};
    logic [`EBR_ADDR_W-1:0] next_addr [2];
    logic [`EBR_DATA_W-1:0] next_din [2];
    logic [`EBR_LANES-1:0] next_be [2];
    logic next_we [2];
    logic next_rd [2];
    // decode of the registered request
    ebr_pkg::ebr_geom_t g [2];
    logic [3:0] off [2];
    logic [`EBR_IDX_W-1:0] idx [2][`EBR_LANES];
    logic [`EBR_BYTE_W-1:0] msk [2][`EBR_LANES];
    logic [`EBR_BYTE_W-1:0] wm [2][`EBR_LANES];
    logic [`EBR_BYTE_W-1:0] nb [2][`EBR_LANES];
    logic [`EBR_DATA_W-1:0] rd_now [2];
    // output registers
    logic [`EBR_DATA_W-1:0] pipe [2] = '{default: `EBR_OUT_RST};
    logic [`EBR_DATA_W-1:0] q [2] = '{default: `EBR_OUT_RST};
    logic cfg_err = 1'b0;
    logic [`EBR_DATA_W-1:0] next_pipe [2];
    logic [`EBR_DATA_W-1:0] next_q [2];
    logic next_err;

    // parity shapes carry nine bits per lane
    function automatic ebr_pkg::ebr_geom_t geom(input ebr_pkg::ebr_shape_t s);
        unique case (s)
            ebr_pkg::shape_1: geom = '{bpl: 4'h1, sh: 2'h3, lgn: 2'h0};
            ebr_pkg::shape_2: geom = '{bpl: 4'h2, sh: 2'h2, lgn: 2'h0};
            ebr_pkg::shape_4: geom = '{bpl: 4'h4, sh: 2'h1, lgn: 2'h0};
            ebr_pkg::shape_8: geom = '{bpl: 4'h8, sh: 2'h0, lgn: 2'h0};
            ebr_pkg::shape_9: geom = '{bpl: 4'h9, sh: 2'h0, lgn: 2'h0};
            ebr_pkg::shape_16: geom = '{bpl: 4'h8, sh: 2'h0, lgn: 2'h1};
            ebr_pkg::shape_18: geom = '{bpl: 4'h9, sh: 2'h0, lgn: 2'h1};
            ebr_pkg::shape_32: geom = '{bpl: 4'h8, sh: 2'h0, lgn: 2'h2};
            ebr_pkg::shape_36: geom = '{bpl: 4'h9, sh: 2'h0, lgn: 2'h2};
            default: geom = '{bpl: 4'h1, sh: 2'h3, lgn: 2'h0};
        endcase
    endfunction

    function automatic logic is_wide(input ebr_pkg::ebr_shape_t s);
        is_wide = (s == ebr_pkg::shape_32) || (s == ebr_pkg::shape_36);
    endfunction

    // which port may write in each mode
    function automatic logic wr_ok(input int p, input logic k, input logic w);
        unique case (mode_i)
            ebr_pkg::mode_single: wr_ok = (p == 0) || k;
            ebr_pkg::mode_simple_dual: wr_ok = (p == 0);
            ebr_pkg::mode_true_dual: wr_ok = !w;
            ebr_pkg::mode_rom: wr_ok = 1'b0;
        endcase
        if (k && w) begin
            wr_ok = 1'b0;
        end
    endfunction

    // which port may read in each mode
    function automatic logic rd_ok(input int p, input logic k, input logic w);
        unique case (mode_i)
            ebr_pkg::mode_single: rd_ok = (p == 0) || k;
            ebr_pkg::mode_simple_dual: rd_ok = (p == 1);
            ebr_pkg::mode_true_dual: rd_ok = !w;
            ebr_pkg::mode_rom: rd_ok = 1'b1;
        endcase
        if (k && w) begin
            rd_ok = 1'b0;
        end
    endfunction

    // gather both ports into arrays
    always_comb begin
        p_addr = '{a_addr_i, b_addr_i};
        p_din = '{a_din_i, b_din_i};
        p_be = '{a_be_i, b_be_i};
        p_en = '{a_en_i, b_en_i};
        p_hold = '{a_addr_hold_i, b_addr_hold_i};
        p_we = '{a_we_i, b_we_i};
        p_rd = '{a_rd_i, b_rd_i};
        outreg = '{a_outreg_i, b_outreg_i};
        shape = '{a_shape_i, b_shape_i};
        pk = packed_i && (mode_i == ebr_pkg::mode_single);
        wide = {is_wide(b_shape_i), is_wide(a_shape_i)};
    end

    // request capture into the input registers
    // address hold keeps the old address
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            next_addr[p] = (p_en[p] && !p_hold[p]) ? p_addr[p] : in_addr[p];
            next_din[p] = p_en[p] ? p_din[p] : in_din[p];
            next_be[p] = p_en[p] ? p_be[p] : in_be[p];
            // wide shapes refused in true dual-port
            next_we[p] = p_en[p] && p_we[p] && wr_ok(p, pk, wide[p]);
            next_rd[p] = p_en[p] && p_rd[p] && rd_ok(p, pk, wide[p]);
        end
    end

    // single clock, no clear on input registers
    always_ff @(posedge clk_sys_i) begin
        in_addr <= next_addr;
        in_din <= next_din;
        in_be <= next_be;
        in_we <= next_we;
        in_rd <= next_rd;
    end

    // lane decode, write merge and read data of the registered request
    always_comb begin
        logic [`EBR_BYTE_W-1:0] wd;
        logic lane_on;
        wd = '0;
        lane_on = 1'b0;
        for (int p = 0; p < 2; p++) begin
            g[p] = geom(shape[p]);
            off[p] = 4'((in_addr[p][2:0] & ((3'h1 << g[p].sh) - 3'h1)) * g[p].bpl);
            rd_now[p] = '0;
            for (int l = 0; l < `EBR_LANES; l++) begin
                idx[p][l] = 9'(((in_addr[p] >> g[p].sh) << g[p].lgn) + 12'(l));
                // packed mode gives each port its own half
                if (pk) begin
                    idx[p][l][8] = 1'(p);
                end
                msk[p][l] = 9'((10'h1 << g[p].bpl) - 10'h1) << off[p];
                lane_on = 3'(l) < (3'h1 << g[p].lgn);
                // disabled bytes get an empty mask
                wm[p][l] = (in_we[p] && in_be[p][l] && lane_on) ? msk[p][l] : 9'h0;
                wd = 9'((in_din[p] >> (l * g[p].bpl)) << off[p]);
                nb[p][l] = (mem[idx[p][l]] & ~wm[p][l]) | (wd & wm[p][l]);
                // own write merged into read data
                // other port's write not seen this cycle
                if (lane_on) begin
                    rd_now[p] = rd_now[p]
                        | (36'((nb[p][l] & msk[p][l]) >> off[p]) << (l * g[p].bpl));
                end
            end
        end
    end

    function automatic ebr_store_t load_image();
        ebr_store_t m;
        for (int i = 0; i < `EBR_BYTES; i++) begin
            m[i] = INIT_IMAGE[i*`EBR_BYTE_W +: `EBR_BYTE_W];
        end
        return m;
    endfunction

    // both ports write in one edge, port b last on a clash
    always_ff @(posedge clk_sys_i) begin
        for (int p = 0; p < 2; p++) begin
            for (int l = 0; l < `EBR_LANES; l++) begin
                if (|wm[p][l]) begin
                    mem[idx[p][l]] <= nb[p][l];
                end
            end
        end
    end

    // optional output register after the read latch
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            next_pipe[p] = in_rd[p] ? rd_now[p] : pipe[p];
            next_q[p] = outreg[p] ? pipe[p] : next_pipe[p];
        end
        next_err = (mode_i == ebr_pkg::mode_true_dual || pk) && (|wide);
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pipe <= '{default: `EBR_OUT_RST};
            q <= '{default: `EBR_OUT_RST};
            cfg_err <= 1'b0;
        end else begin
            pipe <= next_pipe;
            q <= next_q;
            cfg_err <= next_err;
        end
    end

    // outputs straight from the registers
    assign a_q_o = q[0];
    assign b_q_o = q[1];
    assign cfg_err_o = cfg_err;

    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    // checks per port
    for (genvar gp = 0; gp < 2; gp++) begin : g_chk
        sequence s_take;
            p_en[gp] && !p_hold[gp];
        endsequence
        sequence s_bypass_rd;
            in_rd[gp] && !outreg[gp];
        endsequence
        sequence s_piped_rd;
            in_rd[gp] && outreg[gp] ##1 outreg[gp];
        endsequence

        addr_capture_a: assert property (s_take |=> in_addr[gp] == $past(p_addr[gp]))
            else $error("address not captured");
        addr_hold_a: assert property (p_en[gp] && p_hold[gp] |=> $stable(in_addr[gp]))
            else $error("address changed while held");
        bypass_out_a: assert property (s_bypass_rd |=> q[gp] == $past(rd_now[gp]))
            else $error("bypassed read not one cycle");
        piped_out_a: assert property (s_piped_rd |=> q[gp] == $past(rd_now[gp], 2))
            else $error("registered read not two cycles");
        wide_refused_a: assert property (
            mode_i == ebr_pkg::mode_true_dual && wide[gp] |=> !in_we[gp] && cfg_err)
            else $error("wide shape written in true dual-port");
        rom_no_write_a: assert property (mode_i == ebr_pkg::mode_rom |=> !in_we[gp])
            else $error("write taken in rom mode");
        packed_half_a: assert property (
            pk && in_we[gp] && shape[gp] == ebr_pkg::shape_9
            |-> idx[gp][0] == {1'(gp), in_addr[gp][7:0]})
            else $error("packed port left its half");
        new_data_a: assert property (
            in_we[gp] && in_be[gp][0] && in_rd[gp] && !outreg[gp]
            |=> 9'(q[gp]) == 9'($past(in_din[gp]) & ((36'h1 << $past(g[gp].bpl)) - 36'h1)))
            else $error("same-port read missed new data");
        mask_keep_a: assert property (
            in_we[gp] && !in_be[gp][1] && g[gp].lgn != 2'h0 && !in_we[1-gp]
            |=> mem[$past(idx[gp][1])] == $past(mem[idx[gp][1]]))
            else $error("masked byte changed");
        old_data_a: assert property (
            in_rd[gp] && !in_we[gp] && !outreg[gp] && wm[1-gp][0] != 9'h0
            && idx[1-gp][0] == idx[gp][0]
            |=> 9'(q[gp]) == $past(9'((mem[idx[gp][0]] & msk[gp][0]) >> off[gp])))
            else $error("mixed-port read saw new data");
    end
    out_clear_a: assert property (disable iff (1'b0) sys_rst_i |=> a_q_o == `EBR_OUT_RST
        && b_q_o == `EBR_OUT_RST && !cfg_err_o)
        else $error("outputs not cleared");
endmodule

// File: shared/ebr_map.svh
`ifndef EBR_MAP_SVH
`define EBR_MAP_SVH
// storage size including one parity bit per byte
`define EBR_BITS 4608
// storage seen as 9-bit bytes
`define EBR_BYTES 512
`define EBR_BYTE_W 9
`define EBR_IDX_W 9
// port widths
`define EBR_ADDR_W 12
`define EBR_DATA_W 36
`define EBR_LANES 4
// reset value of the output registers
`define EBR_OUT_RST 36'h0
`endif

// File: shared/ebr_pkg.sv
package ebr_pkg;
    // memory organisation
    typedef enum logic [1:0] {
        mode_single,
        mode_simple_dual,
        mode_true_dual,
        mode_rom
    } ebr_mode_t;
    // depth by width shapes of one port
    typedef enum logic [3:0] {
        shape_1,
        shape_2,
        shape_4,
        shape_8,
        shape_9,
        shape_16,
        shape_18,
        shape_32,
        shape_36
    } ebr_shape_t;
    // bits per lane, address bits inside a byte, log2 of lanes
    typedef struct packed {
        logic [3:0] bpl;
        logic [1:0] sh;
        logic [1:0] lgn;
    } ebr_geom_t;
endpackage

// File: verification/ebr_fabric_model.sv
`include "ebr_map.svh"
// fabric logic in front of one port: one request at a time
module ebr_fabric_model (
    // clock
    input wire logic clk_sys_i,
    // port request
    output logic en_o,
    output logic hold_o,
    output logic we_o,
    output logic rd_o,
    output logic [`EBR_ADDR_W-1:0] addr_o,
    output logic [`EBR_DATA_W-1:0] din_o,
    output logic [`EBR_LANES-1:0] be_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle until asked
    initial begin
        en_o = 1'b0;
        hold_o = 1'b0;
        we_o = 1'b0;
        rd_o = 1'b0;
        addr_o = '0;
        din_o = '0;
        be_o = '0;
    end

    // no queue use, so never a read with a write on an empty queue
    task automatic op(input logic we, input logic rd, input logic hold,
            input logic [`EBR_ADDR_W-1:0] addr, input logic [`EBR_DATA_W-1:0] din,
            input logic [`EBR_LANES-1:0] be);
        @(posedge clk_sys_i);
        en_o <= 1'b1;
        we_o <= we;
        rd_o <= rd;
        hold_o <= hold;
        addr_o <= addr;
        din_o <= din;
        be_o <= be;
        @(posedge clk_sys_i);
        // strobes drop and address, data and byte enables show the inverse so stale values never pass
        en_o <= 1'b0;
        we_o <= 1'b0;
        rd_o <= 1'b0;
        addr_o <= ~addr;
        din_o <= ~din;
        be_o <= ~be;
    endtask
endmodule

// File: verification/testbench.sv
`include "ebr_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and configuration
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ebr_pkg::ebr_mode_t mode_i = ebr_pkg::mode_single;
    ebr_pkg::ebr_shape_t a_shape_i = ebr_pkg::shape_36;
    ebr_pkg::ebr_shape_t b_shape_i = ebr_pkg::shape_36;
    logic packed_i = 1'b0;
    logic a_outreg_i = 1'b0;
    logic b_outreg_i = 1'b0;
    // port wires
    logic a_en_i, a_addr_hold_i, a_we_i, a_rd_i, b_en_i, b_addr_hold_i, b_we_i, b_rd_i;
    logic [`EBR_ADDR_W-1:0] a_addr_i, b_addr_i;
    logic [`EBR_DATA_W-1:0] a_din_i, b_din_i, a_q_o, b_q_o;
    logic [`EBR_LANES-1:0] a_be_i, b_be_i;
    logic cfg_err_o;
    int n_errors = 0;
    int compares = 0;

    // preload image: byte i holds i*37+11
    function automatic logic [`EBR_BITS-1:0] mk_img();
        logic [`EBR_BITS-1:0] v;
        for (int i = 0; i < `EBR_BYTES; i++) begin
            v[i*9 +: 9] = 9'(i * 37 + 11);
        end
        return v;
    endfunction
    localparam logic [`EBR_BITS-1:0] IMG = mk_img();

    // expected read of the preload image for one shape
    function automatic logic [35:0] img_rd(input int s, input int addr);
        int bpl[9] = '{1, 2, 4, 8, 9, 8, 9, 8, 9};
        int n[9] = '{1, 1, 1, 1, 1, 2, 2, 4, 4};
        logic [35:0] v = '0;
        int idx;
        for (int l = 0; l < n[s]; l++) begin
            for (int k = 0; k < bpl[s]; k++) begin
                if (bpl[s] < 8) idx = (addr * bpl[s] + k) / 8 * 9 + (addr * bpl[s] + k) % 8;
                else idx = (addr * n[s] + l) * 9 + k;
                v[l * bpl[s] + k] = IMG[idx];
            end
        end
        return v;
    endfunction

    ebr_block_ram #(.INIT_IMAGE(IMG)) i_ebr_block_ram (
        .clk_sys_i, .sys_rst_i, .mode_i, .packed_i, .a_shape_i, .b_shape_i,
        .a_outreg_i, .b_outreg_i, .a_en_i, .a_addr_hold_i, .a_addr_i, .a_din_i,
        .a_be_i, .a_we_i, .a_rd_i, .a_q_o, .b_en_i, .b_addr_hold_i, .b_addr_i,
        .b_din_i, .b_be_i, .b_we_i, .b_rd_i, .b_q_o, .cfg_err_o);
    ebr_fabric_model port_a (.clk_sys_i, .en_o(a_en_i), .hold_o(a_addr_hold_i),
        .we_o(a_we_i), .rd_o(a_rd_i), .addr_o(a_addr_i), .din_o(a_din_i), .be_o(a_be_i));
    ebr_fabric_model port_b (.clk_sys_i, .en_o(b_en_i), .hold_o(b_addr_hold_i),
        .we_o(b_we_i), .rd_o(b_rd_i), .addr_o(b_addr_i), .din_o(b_din_i), .be_o(b_be_i));

    // clock
    always #2.5 clk_sys_i = ~clk_sys_i;

    // comparison, report and verdict
    task automatic chk(input string what, input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic done(input string name);
        $display("test %s finished, mismatches %0d", name, n_errors);
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // wait n edges, then sample on the falling edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task automatic cfg(input ebr_pkg::ebr_mode_t m, input ebr_pkg::ebr_shape_t sa,
            input ebr_pkg::ebr_shape_t sb, input logic ora, input logic pk);
        @(posedge clk_sys_i);
        mode_i <= m;
        a_shape_i <= sa;
        b_shape_i <= sb;
        a_outreg_i <= ora;
        b_outreg_i <= ora;
        packed_i <= pk;
        wt(2);
    endtask

    task automatic t_reset();
        wt(1);
        chk("a_q", a_q_o, '0);
        chk("b_q", b_q_o, '0);
        chk("cfg_err", 36'(cfg_err_o), '0);
        done("reset");
    endtask
    task automatic t_shapes();
        for (int s = 0; s < 9; s++) begin
            cfg(ebr_pkg::mode_rom, ebr_pkg::ebr_shape_t'(s), ebr_pkg::shape_1, 1'b0, 1'b0);
            port_a.op(1'b0, 1'b1, 1'b0, 12'h7f, '0, '0);
            wt(1);
            chk("rom read", a_q_o, img_rd(s, 127));
        end
        done("shapes");
    endtask
    task automatic t_bytes();
        cfg(ebr_pkg::mode_single, ebr_pkg::shape_36, ebr_pkg::shape_36, 1'b0, 1'b0);
        port_a.op(1'b1, 1'b0, 1'b0, 12'h3, 36'hfffffffff, 4'hf);
        port_a.op(1'b1, 1'b1, 1'b0, 12'h3, 36'h0, 4'h5);
        wt(1);
        chk("rdw merge", a_q_o, 36'hff803fe00);
        done("bytes");
    endtask
    task automatic t_outreg();
        cfg(ebr_pkg::mode_single, ebr_pkg::shape_36, ebr_pkg::shape_36, 1'b1, 1'b0);
        port_a.op(1'b0, 1'b1, 1'b0, 12'h7f, '0, '0);
        wt(1);
        chk("outreg early", a_q_o, 36'hff803fe00);
        wt(1);
        chk("outreg late", a_q_o, img_rd(8, 127));
        done("outreg");
    endtask
    task automatic t_hold();
        cfg(ebr_pkg::mode_single, ebr_pkg::shape_36, ebr_pkg::shape_36, 1'b0, 1'b0);
        port_a.op(1'b0, 1'b1, 1'b0, 12'h3, '0, '0);
        port_a.op(1'b0, 1'b1, 1'b1, 12'h7f, '0, '0);
        wt(1);
        chk("held address", a_q_o, 36'hff803fe00);
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        wt(0);
        chk("q after reset", a_q_o, '0);
        port_a.op(1'b0, 1'b1, 1'b0, 12'h3, '0, '0);
        wt(1);
        chk("kept over reset", a_q_o, 36'hff803fe00);
        done("hold");
    endtask
    task automatic t_mixed();
        cfg(ebr_pkg::mode_true_dual, ebr_pkg::shape_18, ebr_pkg::shape_18, 1'b0, 1'b0);
        port_a.op(1'b1, 1'b0, 1'b0, 12'ha, 36'h15a5a, 4'h3);
        fork
            port_a.op(1'b0, 1'b1, 1'b0, 12'ha, '0, '0);
            port_b.op(1'b1, 1'b0, 1'b0, 12'ha, 36'h2a5a5, 4'h3);
        join
        wt(1);
        chk("old data", a_q_o, 36'h15a5a);
        fork
            port_a.op(1'b0, 1'b1, 1'b0, 12'ha, '0, '0);
            port_b.op(1'b0, 1'b1, 1'b0, 12'ha, '0, '0);
        join
        wt(1);
        chk("two reads a", a_q_o, 36'h2a5a5);
        chk("two reads b", b_q_o, 36'h2a5a5);
        done("mixed");
    endtask
    task automatic t_simple();
        cfg(ebr_pkg::mode_simple_dual, ebr_pkg::shape_18, ebr_pkg::shape_18, 1'b0, 1'b0);
        port_a.op(1'b1, 1'b0, 1'b0, 12'h30, 36'h12345, 4'h3);
        port_b.op(1'b1, 1'b0, 1'b0, 12'h30, 36'h3ffff, 4'h3);
        port_b.op(1'b0, 1'b1, 1'b0, 12'h30, '0, '0);
        wt(1);
        chk("simple read b", b_q_o, 36'h12345);
        done("simple");
    endtask
    task automatic t_cfg();
        cfg(ebr_pkg::mode_true_dual, ebr_pkg::shape_36, ebr_pkg::shape_18, 1'b0, 1'b0);
        chk("cfg_err", 36'(cfg_err_o), 36'h1);
        port_a.op(1'b1, 1'b0, 1'b0, 12'h0, 36'hfffffffff, 4'hf);
        cfg(ebr_pkg::mode_true_dual, ebr_pkg::shape_18, ebr_pkg::shape_18, 1'b0, 1'b0);
        chk("cfg_err", 36'(cfg_err_o), '0);
        port_a.op(1'b0, 1'b1, 1'b0, 12'h0, '0, '0);
        wt(1);
        chk("refused write", a_q_o, img_rd(6, 0));
        done("cfg");
    endtask
    task automatic t_packed();
        cfg(ebr_pkg::mode_single, ebr_pkg::shape_9, ebr_pkg::shape_9, 1'b0, 1'b1);
        fork
            port_a.op(1'b1, 1'b0, 1'b0, 12'h0, 36'h1a5, 4'h1);
            port_b.op(1'b1, 1'b0, 1'b0, 12'h0, 36'h05a, 4'h1);
        join
        fork
            port_a.op(1'b0, 1'b1, 1'b0, 12'h0, '0, '0);
            port_b.op(1'b0, 1'b1, 1'b0, 12'h0, '0, '0);
        join
        wt(1);
        chk("packed a", a_q_o, 36'h1a5);
        chk("packed b", b_q_o, 36'h05a);
        cfg(ebr_pkg::mode_single, ebr_pkg::shape_9, ebr_pkg::shape_9, 1'b0, 1'b0);
        port_a.op(1'b0, 1'b1, 1'b0, 12'h100, '0, '0);
        wt(1);
        chk("upper half", a_q_o, 36'h05a);
        done("packed");
    endtask

    // reset, then scenarios in order
    initial begin
        repeat (6) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_shapes();
        t_bytes();
        t_outreg();
        t_hold();
        t_mixed();
        t_simple();
        t_cfg();
        t_packed();
        end_of_test();
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        n_errors++;
        end_of_test();
    end
endmodule
